// ### design/mhr_defines.svh
// register addresses, function codes, limits and reset values
`ifndef MHR_DEFINES_SVH
`define MHR_DEFINES_SVH

// function codes
`define MHR_FC_RD_HOLD   8'h03
`define MHR_FC_RD_INPUT  8'h04
`define MHR_FC_WR_SINGLE 8'h06
`define MHR_FC_RD_EXC    8'h07
`define MHR_FC_SLAVE_ID  8'h11
`define MHR_FC_WR_MULTI  8'h16

// exception codes
`define MHR_EX_NONE      8'h00
`define MHR_EX_ILL_FUNC  8'h01
`define MHR_EX_ILL_ADDR  8'h02
`define MHR_EX_ILL_VAL   8'h03

// action key
`define MHR_ACTION_KEY   16'h3247

// holding register addresses
`define MHR_A_RESET      16'h0000
`define MHR_A_MEAS_START 16'h0001
`define MHR_A_MEAS_STOP  16'h0002
`define MHR_A_LASER_ON   16'h0003
`define MHR_A_LASER_OFF  16'h0004
`define MHR_A_CAL_AH     16'h0005
`define MHR_A_CAL_H      16'h0006
`define MHR_A_DEF_START  16'h0007
`define MHR_A_DEF_STOP   16'h0008
`define MHR_A_LAST_ACT   16'h0008
`define MHR_A_BLK_MODE   16'h0009
`define MHR_A_WIN_MODE   16'h000a
`define MHR_A_EXT_PIN    16'h000b
`define MHR_A_PON_DEF    16'h000c
`define MHR_A_REF_HGT    16'h000d
`define MHR_A_REF_TILT   16'h000e
`define MHR_A_LIVE_ANG   16'h000f
`define MHR_A_ACC_TIME   16'h0010
`define MHR_A_MAX_STEP   16'h0011
`define MHR_A_LSR_MODE   16'h0012
`define MHR_A_LSR_IVL    16'h0013
`define MHR_A_LAST       16'h0013

// parameter limits
`define MHR_MODE_MAX     16'h0003
`define MHR_BOOL_MAX     16'h0001
`define MHR_HGT_LIM      16'sd16000
`define MHR_TILT_LIM     16'sd180
`define MHR_STEP_LIM     16'sd20000
`define MHR_IVL_MIN      16'd1000
`define MHR_IVL_MAX      16'd60000

// addressing
`define MHR_ADDR_MAX     8'd247
`define MHR_BROADCAST    8'h00

// reset values of the active parameter set
`define MHR_RST_IVL      16'd10000
`define MHR_RST_STEP     16'd20
`define MHR_RST_ACC      16'd600

`endif

// ### design/mhr_pkg.sv
// types shared by the holding register layer
package mhr_pkg;

  // one decoded register request from the frame layer
  typedef struct packed {
    logic [7:0]  slave_addr;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
  } mhr_req_s;

  // answer returned to the frame layer
  typedef struct packed {
    logic        to_send;
    logic [7:0]  exc;
    logic [15:0] data;
  } mhr_rsp_s;

  // one-hot style action pulses
  typedef struct packed {
    logic sensor_reset;
    logic meas_start;
    logic meas_stop;
    logic laser_on;
    logic laser_off;
    logic cal_angle_height;
    logic cal_height;
    logic defrost_start;
    logic defrost_stop;
  } mhr_act_s;

  typedef enum logic [1:0] {
    MHR_IDLE   = 2'b00,
    MHR_ANSWER = 2'b01
  } mhr_state_e;

endpackage : mhr_pkg

// ### design/mhr_holding_regs.sv
// holding register map and request decode of the modbus slave layer
// Behaviour
// R1 - accept 03 04 06 07 11 16 functions
// R2 - answer slave identity on broadcast too
// R3 - parameters held as 16-bit integers
// R4 - reads return active value only
// R5 - writes stored, active after reset
// R6 - out-of-limit write gets illegal value
// R7 - actions fire only on key 0x3247
// R8 - action not possible gets illegal value
// R9 - action registers read as zero
// R10 - action zero resets the sensor
// R11 - actions 1-8 in documented order
// R12 - state-gated actions refused when not allowed
// R13 - heater modes off auto defrost stop
// R14 - external pin and power-on defrost flags
// R15 - reference height within plus minus 16000
// R16 - angle select, tilt within 180
// R17 - accept time full 16-bit range
// R18 - max height step within 20000
// R19 - laser interval 1000 to 60000
// R20 - slave address is id clamped 247
// R21 - bad address illegal address, value 03
// R22 - laser mode accepts only zero
`timescale 1ns/1ns
`include "mhr_defines.svh"

module mhr_holding_regs
  import mhr_pkg::*;
#(
  parameter int REGS = 20
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  DEVICE_ID,
  input  wire logic        REQ_VALID,
  input  wire mhr_req_s    REQ,
  input  wire logic        MEAS_ACTIVE,
  input  wire logic        LASER_ACTIVE,
  input  wire logic        CAL_ACTIVE,
  input  wire logic        DEFROST_ACTIVE,
  input  wire logic [15:0] NV_DATA,
  input  wire logic        NV_LOAD,
  input  wire logic [4:0]  NV_LOAD_ADDR,
  output logic             RSP_VALID,
  output mhr_rsp_s         RSP,
  output mhr_act_s         ACTION,
  output logic             NV_WRITE,
  output logic [4:0]       NV_WR_ADDR,
  output logic [15:0]      NV_WR_DATA,
  output logic [15:0]      ACTIVE_PARAMS [REGS],
  output logic [7:0]       SLAVE_ADDR
);

  // ------------------------------------------------------------
  // address and function decode
  // ------------------------------------------------------------

  // state inputs come from the sensor core on this clock
  logic [7:0]  own_addr;
  logic        addr_match;
  logic        is_bcast;
  logic        is_write;
  logic        is_read;
  logic        known_func;
  logic        addr_ok;
  logic        is_action;
  logic        key_ok;
  logic        act_allowed;
  logic        val_ok;
  logic [7:0]  exc_d;
  logic        answer;
  logic [15:0] rd_data;

  // limit check per parameter address, used by the write path
  function automatic logic param_in_limits(input logic [15:0] a,
                                           input logic [15:0] v);
    logic signed [15:0] s;
    s = v;
    if (a == `MHR_A_BLK_MODE || a == `MHR_A_WIN_MODE)
      return v <= `MHR_MODE_MAX; // R13
    else if (a == `MHR_A_EXT_PIN || a == `MHR_A_PON_DEF)
      return v <= `MHR_BOOL_MAX; // R14
    else if (a == `MHR_A_REF_HGT)
      return s >= -`MHR_HGT_LIM && s <= `MHR_HGT_LIM; // R15
    else if (a == `MHR_A_REF_TILT)
      return s >= -`MHR_TILT_LIM && s <= `MHR_TILT_LIM; // R16
    else if (a == `MHR_A_LIVE_ANG)
      return v <= `MHR_BOOL_MAX; // R16
    else if (a == `MHR_A_ACC_TIME)
      return 1'b1; // R17
    else if (a == `MHR_A_MAX_STEP)
      return s >= -`MHR_STEP_LIM && s <= `MHR_STEP_LIM; // R18
    else if (a == `MHR_A_LSR_MODE)
      return v == 16'h0000; // R22
    else if (a == `MHR_A_LSR_IVL)
      return v >= `MHR_IVL_MIN && v <= `MHR_IVL_MAX; // R19
    else
      return 1'b0;
  endfunction : param_in_limits

  // slave address, id above the modbus range clamps
  assign own_addr = (DEVICE_ID > `MHR_ADDR_MAX) ? `MHR_ADDR_MAX
                                                : DEVICE_ID; // R20
  assign is_bcast   = REQ.slave_addr == `MHR_BROADCAST;
  assign addr_match = (REQ.slave_addr == own_addr) ||
                      (is_bcast && REQ.func == `MHR_FC_SLAVE_ID); // R2
  assign is_write   = REQ.func == `MHR_FC_WR_SINGLE ||
                      REQ.func == `MHR_FC_WR_MULTI;
  assign is_read    = REQ.func == `MHR_FC_RD_HOLD;
  assign known_func = is_write || is_read ||
                      REQ.func == `MHR_FC_RD_INPUT ||
                      REQ.func == `MHR_FC_RD_EXC ||
                      REQ.func == `MHR_FC_SLAVE_ID; // R1
  assign addr_ok    = REQ.addr <= `MHR_A_LAST;
  assign is_action  = REQ.addr <= `MHR_A_LAST_ACT;
  assign key_ok     = REQ.data == `MHR_ACTION_KEY; // R7

  // ------------------------------------------------------------
  // action gating against the operating state
  // ------------------------------------------------------------

  // an action already running is refused as well as a conflict
  always_comb begin
    act_allowed = 1'b1;
    case (REQ.addr)
      `MHR_A_MEAS_START: act_allowed = !MEAS_ACTIVE && !CAL_ACTIVE; // R12
      `MHR_A_MEAS_STOP:  act_allowed = MEAS_ACTIVE; // R12
      `MHR_A_LASER_ON:   act_allowed = !LASER_ACTIVE && !MEAS_ACTIVE
                                       && !CAL_ACTIVE; // R12
      `MHR_A_LASER_OFF:  act_allowed = LASER_ACTIVE; // R12
      `MHR_A_CAL_AH,
      `MHR_A_CAL_H:      act_allowed = !CAL_ACTIVE && !LASER_ACTIVE; // R12
      `MHR_A_DEF_START:  act_allowed = !DEFROST_ACTIVE; // R8
      `MHR_A_DEF_STOP:   act_allowed = DEFROST_ACTIVE; // R8
      default:           act_allowed = 1'b1;
    endcase
  end

  // write acceptance: key and state for actions, limits for params
  assign val_ok = is_action ? (key_ok && act_allowed)
                            : param_in_limits(REQ.addr, REQ.data);

  // exception selection; illegal value is code 03
  always_comb begin
    exc_d = `MHR_EX_NONE;
    if (!known_func)
      exc_d = `MHR_EX_ILL_FUNC;
    else if ((is_read || is_write) && !addr_ok)
      exc_d = `MHR_EX_ILL_ADDR; // R21
    else if (is_write && !val_ok)
      exc_d = `MHR_EX_ILL_VAL; // R6 R8 R21
  end

  // broadcasts get no answer except slave identity
  assign answer = REQ_VALID && addr_match &&
                  (!is_bcast || REQ.func == `MHR_FC_SLAVE_ID); // R2

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------

  // active set only changes on reset and on an nv load, so a
  // write is not seen on read-back until its slot is loaded from nv
  logic [15:0] active_q [REGS];
  logic        do_write;
  logic        do_param;
  logic        do_action;

  assign do_write  = REQ_VALID && addr_match && is_write &&
                     addr_ok && val_ok;
  assign do_param  = do_write && !is_action; // R5
  assign do_action = do_write && is_action; // R7

  // parameter slots load from nv storage, actions keep zero
  genvar g;
  generate
    for (g = 0; g < REGS; g++) begin : g_reg
      always_ff @(posedge CLK) begin
        if (RST)
          active_q[g] <= (g == 19) ? `MHR_RST_IVL :
                         (g == 17) ? `MHR_RST_STEP :
                         (g == 16) ? `MHR_RST_ACC : 16'h0000;
        else if (NV_LOAD && NV_LOAD_ADDR == 5'(g) &&
                 g > int'(`MHR_A_LAST_ACT))
          active_q[g] <= NV_DATA; // R3 R5
      end
      assign ACTIVE_PARAMS[g] = active_q[g];
    end
  endgenerate

  // read data: actions read zero, params read the active value
  assign rd_data = is_action ? 16'h0000 // R9
                             : active_q[REQ.addr[4:0]]; // R4

  // ------------------------------------------------------------
  // response, nv write and action pulses
  // ------------------------------------------------------------

  mhr_state_e state_q;
  mhr_state_e state_d;

  assign state_d = answer ? MHR_ANSWER : MHR_IDLE;

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q    <= MHR_IDLE;
      RSP        <= '0;
      NV_WRITE   <= 1'b0;
      NV_WR_ADDR <= 5'h00;
      NV_WR_DATA <= 16'h0000;
      ACTION     <= '0;
      SLAVE_ADDR <= 8'h00;
    end else begin
      state_q    <= state_d;
      SLAVE_ADDR <= own_addr; // R20
      NV_WRITE   <= do_param; // R5
      if (do_param) begin
        NV_WR_ADDR <= REQ.addr[4:0];
        NV_WR_DATA <= REQ.data;
      end
      // one-cycle action pulses in register order
      ACTION.sensor_reset <= do_action && REQ.addr == `MHR_A_RESET; // R10
      ACTION.meas_start <= do_action && REQ.addr == `MHR_A_MEAS_START; // R11
      ACTION.meas_stop <= do_action && REQ.addr == `MHR_A_MEAS_STOP; // R11
      ACTION.laser_on <= do_action && REQ.addr == `MHR_A_LASER_ON; // R11
      ACTION.laser_off <= do_action && REQ.addr == `MHR_A_LASER_OFF; // R11
      ACTION.cal_angle_height <= do_action && REQ.addr == `MHR_A_CAL_AH; // R11
      ACTION.cal_height <= do_action && REQ.addr == `MHR_A_CAL_H; // R11
      ACTION.defrost_start <= do_action && REQ.addr == `MHR_A_DEF_START; // R11
      ACTION.defrost_stop <= do_action && REQ.addr == `MHR_A_DEF_STOP; // R11
      if (answer) begin
        RSP.to_send <= 1'b1;
        RSP.exc     <= exc_d;
        RSP.data    <= (is_read && exc_d == `MHR_EX_NONE) ? rd_data
                                                        : REQ.data;
      end else begin
        RSP.to_send <= 1'b0;
      end
    end
  end

  // response strobe follows the answer state
  assign RSP_VALID = state_q == MHR_ANSWER;

endmodule : mhr_holding_regs

// ### testbench/mhr_holding_regs_monitor.sv
// assertion checker for the holding register layer
`timescale 1ns/1ns
`include "mhr_defines.svh"
module mhr_holding_regs_monitor
  import mhr_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [7:0] DEVICE_ID,
  input wire logic       REQ_VALID,
  input wire mhr_req_s   REQ,
  input wire logic       RSP_VALID,
  input wire mhr_rsp_s   RSP,
  input wire mhr_act_s   ACTION,
  input wire logic       NV_WRITE,
  input wire logic [7:0] SLAVE_ADDR
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RST);
  // request meant for us; broadcast counts only for identity
  wire tk = REQ_VALID && ((SLAVE_ADDR != 8'h00 && REQ.slave_addr == SLAVE_ADDR)
    || (REQ.slave_addr == 8'h00 && REQ.func == `MHR_FC_SLAVE_ID));
  // ----------
  // properties
  // ----------
  property p_answer; tk |=> RSP_VALID; endproperty
  a_answer: assert property (p_answer)
    else $error("taken request not answered");
  property p_silent; !tk |=> !RSP_VALID; endproperty
  a_silent: assert property (p_silent)
    else $error("answer without own request");
  property p_key; (|ACTION) |-> $past(REQ.data) == `MHR_ACTION_KEY
    && RSP_VALID && RSP.exc == `MHR_EX_NONE; endproperty
  a_key: assert property (p_key)
    else $error("action without key or good answer");
  property p_rst; ACTION.sensor_reset |-> $past(REQ.addr) == `MHR_A_RESET;
  endproperty
  a_rst: assert property (p_rst)
    else $error("sensor reset from wrong address");
  property p_zero; RSP_VALID && $past(REQ.func) == `MHR_FC_RD_HOLD
    && $past(REQ.addr) <= `MHR_A_LAST_ACT |-> RSP.data == 16'h0000; endproperty
  a_zero: assert property (p_zero)
    else $error("action register read not zero");
  property p_badadr; tk && REQ.func == `MHR_FC_RD_HOLD
    && REQ.addr > `MHR_A_LAST |=> RSP.exc == `MHR_EX_ILL_ADDR; endproperty
  a_badadr: assert property (p_badadr)
    else $error("bad address not refused");
  property p_ivl; tk && REQ.func == `MHR_FC_WR_SINGLE
    && REQ.addr == `MHR_A_LSR_IVL
    && (REQ.data < `MHR_IVL_MIN || REQ.data > `MHR_IVL_MAX)
    |=> RSP.exc == `MHR_EX_ILL_VAL && !NV_WRITE; endproperty
  a_ivl: assert property (p_ivl)
    else $error("interval out of limits accepted");
  property p_nv; NV_WRITE |-> RSP_VALID && RSP.exc == `MHR_EX_NONE; endproperty
  a_nv: assert property (p_nv)
    else $error("store without good answer");
  property p_slave; 1'b1 |=> SLAVE_ADDR == ($past(DEVICE_ID) > `MHR_ADDR_MAX
    ? `MHR_ADDR_MAX : $past(DEVICE_ID)); endproperty
  a_slave: assert property (p_slave)
    else $error("slave address not clamped id");
endmodule : mhr_holding_regs_monitor

bind mhr_holding_regs mhr_holding_regs_monitor i_mon (
  .CLK(CLK), .RST(RST), .DEVICE_ID(DEVICE_ID), .REQ_VALID(REQ_VALID),
  .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP(RSP), .ACTION(ACTION),
  .NV_WRITE(NV_WRITE), .SLAVE_ADDR(SLAVE_ADDR)
);

// ### testbench/mhr_master_model.sv
// modbus master stand-in issuing one decoded request per clock with GO high
`timescale 1ns/1ns
module mhr_master_model
  import mhr_pkg::*;
(
  input  wire logic     CLK,
  input  wire logic     GO,
  input  wire mhr_req_s CMD,
  output mhr_req_s      REQ,
  output logic          REQ_VALID
);
  // idle cycles invert the word each clock, so the stale request shows again on every second idle cycle
  always_ff @(posedge CLK) begin
    REQ_VALID <= GO;
    REQ       <= GO ? CMD : ~REQ;
  end
endmodule : mhr_master_model

// ### testbench/tb_modbus_holding_register_map.sv
// self-checking bench for the holding register layer
`timescale 1ns/1ns
`include "mhr_defines.svh"
module tb_modbus_holding_register_map
  import mhr_pkg::*;
;
  typedef struct packed {
    logic [7:0]  e;
    logic [15:0] d;
    mhr_act_s    a;
    logic        w;
    logic [4:0]  wa;
  } mhr_note_s;
  localparam logic [8:0] OK_IDLE = 9'h0eb; // actions allowed when all idle
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, nv_ld = 1'b0;
  logic [3:0] st = 4'h0;
  logic [4:0] nv_a = 5'h00;
  logic [4:0] nv_wa;
  logic [7:0] dev_id = 8'd250, slv, xe;
  logic [15:0] nv_d = 16'h0000, nv_wd, prm [20];
  mhr_req_s cmd = '0, req;
  mhr_rsp_s rsp;
  mhr_act_s act;
  logic req_v, rsp_v, nv_w;
  mhr_note_s q[$], n;
  int bad_count = 0, num_checks = 0, seed = 68098, cyc = 0, v;
  logic [39:0] lim [18] = '{40'h06_13_03e7_03, 40'h16_13_ea61_03,
    40'h06_13_03e8_00, 40'h06_13_ea60_00, 40'h06_0d_3e81_03,
    40'h16_0d_c180_00, 40'h06_0e_00b5_03, 40'h06_0e_ff4c_00,
    40'h06_11_b1df_03, 40'h06_11_4e20_00, 40'h06_12_0001_03,
    40'h06_12_0000_00, 40'h06_09_0004_03, 40'h06_0a_0003_00,
    40'h06_0b_0002_03, 40'h06_0c_0001_00, 40'h06_0f_0002_03,
    40'h06_10_ffff_00};

  mhr_master_model i_mst (.CLK(clk), .GO(go), .CMD(cmd), .REQ(req),
    .REQ_VALID(req_v));
  mhr_holding_regs i_dut (.CLK(clk), .RST(rst), .DEVICE_ID(dev_id),
    .REQ_VALID(req_v), .REQ(req), .MEAS_ACTIVE(st[3]), .LASER_ACTIVE(st[2]),
    .CAL_ACTIVE(st[1]), .DEFROST_ACTIVE(st[0]), .NV_DATA(nv_d),
    .NV_LOAD(nv_ld), .NV_LOAD_ADDR(nv_a), .RSP_VALID(rsp_v), .RSP(rsp),
    .ACTION(act), .NV_WRITE(nv_w), .NV_WR_ADDR(nv_wa), .NV_WR_DATA(nv_wd),
    .ACTIVE_PARAMS(prm), .SLAVE_ADDR(slv));

  // -------
  // helpers
  // -------
  task automatic chk(input string s, input logic [15:0] ex, got);
    num_checks++;
    if (got !== ex) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", s, ex, got);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // e of ff means no answer is due, so nothing is queued
  task automatic rq(input logic [7:0] f, input logic [15:0] a, d,
                    input logic [7:0] e, input logic [7:0] s = 8'd247);
    mhr_note_s m;
    logic      wr;
    wr  = (f == `MHR_FC_WR_SINGLE || f == `MHR_FC_WR_MULTI) && e == 8'h00;
    m.e = e;
    m.d = d;
    m.a = (wr && a <= `MHR_A_LAST_ACT) ? mhr_act_s'(9'h100 >> a) : '0;
    m.w = wr && a > `MHR_A_LAST_ACT;
    m.wa = a[4:0];
    if (e != 8'hff) q.push_back(m);
    @(posedge clk);
    go  <= 1'b1;
    cmd <= '{s, f, a, d};
  endtask : rq

  task automatic idle;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : idle

  // clock and hang guard
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      final_report();
    end
  end

  // answer watcher: oldest note against each answer
  always @(posedge clk) begin
    if (rsp_v === 1'b1) begin
      if (q.size() == 0) chk("spare answer", 16'h0, 16'h1);
      else begin
        n = q.pop_front();
        chk("exc", n.e, rsp.exc);
        if (n.e == 8'h00) chk("data", n.d, rsp.data);
        chk("action", n.a, act);
        chk("store", n.w, nv_w);
        if (n.w) chk("store data", n.d, nv_wd);
        if (n.w) chk("store addr", {11'h000, n.wa}, {11'h000, nv_wa});
      end
    end
  end

  // -----
  // tests
  // -----
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset acc", `MHR_RST_ACC, prm[16]);
    chk("reset step", `MHR_RST_STEP, prm[17]);
    rq(`MHR_FC_WR_SINGLE, `MHR_A_LSR_IVL, 16'd5000, 8'h00);
    rq(`MHR_FC_RD_HOLD, `MHR_A_LSR_IVL, `MHR_RST_IVL, 8'h00);
    idle();
    nv_a  <= 5'd19;
    nv_d  <= 16'd5000;
    nv_ld <= 1'b1;
    @(posedge clk) nv_ld <= 1'b0;
    rq(`MHR_FC_RD_HOLD, `MHR_A_LSR_IVL, 16'd5000, 8'h00);
    idle();
    chk("slave addr", 16'd247, {8'h00, slv});
    $display("test reload done");
    foreach (lim[i]) rq(lim[i][39:32], {8'h00, lim[i][31:24]}, lim[i][23:8],
      lim[i][7:0]);
    idle();
    $display("test limits done");
    for (int s = 0; s < 2; s++) begin
      @(posedge clk) st <= {4{s[0]}};
      for (int a = 0; a < 9; a++) begin
        xe = (a == 0 || (OK_IDLE[a] ^ s[0])) ? 8'h00 : 8'h03;
        rq(`MHR_FC_WR_SINGLE, a[15:0], `MHR_ACTION_KEY, xe);
      end
      rq(`MHR_FC_WR_SINGLE, 16'h0001, 16'h3246, 8'h03);
      idle();
    end
    $display("test actions done");
    for (int a = 0; a < 9; a++) begin
      rq(`MHR_FC_RD_HOLD, a[15:0], 16'h0000, 8'h00);
    end
    rq(`MHR_FC_RD_INPUT, 16'h0005, 16'h1234, 8'h00);
    rq(`MHR_FC_RD_EXC, 16'h0000, 16'h0000, 8'h00);
    rq(`MHR_FC_SLAVE_ID, 16'h0000, 16'h0042, 8'h00, 8'h00);
    rq(8'h05, 16'h0000, 16'h0000, `MHR_EX_ILL_FUNC);
    rq(`MHR_FC_RD_HOLD, 16'h0014, 16'h0000, `MHR_EX_ILL_ADDR);
    rq(`MHR_FC_WR_SINGLE, 16'h000d, 16'h0001, 8'hff, 8'h00);
    rq(`MHR_FC_RD_HOLD, 16'h000d, 16'h0000, 8'hff, 8'd250);
    repeat (12) begin
      v = $random(seed) % 16001;
      rq(`MHR_FC_WR_SINGLE, `MHR_A_REF_HGT, v[15:0], 8'h00);
    end
    idle();
    // an id inside the modbus range is used as it stands
    dev_id <= 8'd17;
    repeat (2) @(posedge clk);
    chk("slave addr", 16'd17, {8'h00, slv});
    rq(`MHR_FC_RD_HOLD, `MHR_A_REF_HGT, 16'h0000, 8'h00, 8'd17);
    idle();
    $display("test functions done");
    chk("pending", 16'h0, q.size());
    final_report();
  end
endmodule : tb_modbus_holding_register_map
